// ==== rtl/nps_params.svh ====
// Constants of the phase-to-sine datapath: register offsets, field
// positions, reset values and the pipeline latency.
// Assumes a 32-bit APB bus with byte addresses and one word per register.
`ifndef NPS_PARAMS_SVH
`define NPS_PARAMS_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define NPS_OFS_CTRL    8'h00
`define NPS_OFS_FREQ_A  8'h04
`define NPS_OFS_FREQ_B  8'h08
`define NPS_OFS_PHASE_A 8'h0C
`define NPS_OFS_PHASE_B 8'h10
`define NPS_OFS_STATUS  8'h14

// ***************************************************************
// Control register fields and reset values
// ***************************************************************
`define NPS_BIT_FREQ_SEL  11
`define NPS_BIT_PSEL  10
`define NPS_BIT_MODE  1
`define NPS_RST_CTRL  16'h0000
`define NPS_RST_WORD  32'h0000_0000

// Cycles from a register write to the converter word, falling-edge path
`define NPS_LATENCY_CYCLES 7

`endif

// ==== rtl/nps_pkg.sv ====
// Types shared by the phase-to-sine datapath.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package nps_pkg;

   // ***************************************************************
   // Control fields carried together
   // ***************************************************************
   typedef struct packed {
      logic freq_word_select;
      logic phase_offset_select;
      logic ramp_mode;
   } nps_ctrl_t;

endpackage : nps_pkg
`default_nettype wire

// ==== rtl/nps_nco_datapath.sv ====
// Phase accumulator, phase offset, sine table and output buffer,
// with an APB register slave.
// Assumes dac_ready comes from logic on pclk; APB master on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "nps_params.svh"

module nps_nco_datapath #(
   parameter int ACC_W = 28,
   parameter int PHASE_W = 12,
   parameter int DAC_W = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dac_ready,
   output logic [DAC_W-1:0] dac_data,
   output logic dac_valid
);

   // ***************************************************************
   // Parameter checks
   // ***************************************************************
   // Table needs two phase bits over the converter width
   if (PHASE_W != DAC_W + 2 || ACC_W < PHASE_W || ACC_W > 32) begin : g_chk
      $error("nps_nco_datapath: unsupported widths");
   end

   // ***************************************************************
   // Sine table
   // ***************************************************************
   // Bhaskara form over a half cycle; offset binary around mid-scale
   function automatic logic [DAC_W-1:0] sine_of(input int idx);
      longint half;
      longint h;
      longint u;
      longint amp;
      longint mid;
      half = longint'(1) << (PHASE_W - 1);
      h = longint'(idx) % half;
      u = h * (half - h);
      mid = longint'(1) << (DAC_W - 1);
      amp = (4 * (mid - 1) * u) / ((5 * half * half) / 4 - u);
      if (idx >= half) begin
         amp = -amp;
      end
      return DAC_W'(mid + amp);
   endfunction : sine_of

   logic [DAC_W-1:0] sine_rom [1 << PHASE_W];

   // Constant table filled by an initial block at time zero
   initial begin
      for (int i = 0; i < (1 << PHASE_W); i++) begin
         sine_rom[i] = sine_of(i);
      end
   end

   // ***************************************************************
   // APB register slave
   // ***************************************************************
   function automatic logic addr_hit(input logic [7:0] a);
      return a == `NPS_OFS_CTRL || a == `NPS_OFS_FREQ_A ||
             a == `NPS_OFS_FREQ_B || a == `NPS_OFS_PHASE_A ||
             a == `NPS_OFS_PHASE_B || a == `NPS_OFS_STATUS;
   endfunction : addr_hit

   nps_pkg::nps_ctrl_t ctrl;
   nps_pkg::nps_ctrl_t next_ctrl;
   logic [ACC_W-1:0] frequency_word_a;
   logic [ACC_W-1:0] frequency_word_b;
   logic [PHASE_W-1:0] phase_offset_a;
   logic [PHASE_W-1:0] phase_offset_b;
   logic [ACC_W-1:0] next_freq_a;
   logic [ACC_W-1:0] next_freq_b;
   logic [PHASE_W-1:0] next_off_a;
   logic [PHASE_W-1:0] next_off_b;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [ACC_W-1:0] acc;
   logic [15:0] ctrl_word;
   logic commit;

   // Whole control word as software sees it; other bits read zero
   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[`NPS_BIT_FREQ_SEL] = ctrl.freq_word_select;
      ctrl_word[`NPS_BIT_PSEL] = ctrl.phase_offset_select;
      ctrl_word[`NPS_BIT_MODE] = ctrl.ramp_mode;
   end

   // Answer one cycle into the access phase; write lands with pready
   always_comb begin
      commit = psel && penable && pready;
      next_pready = psel && penable && !pready;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      next_ctrl = ctrl;
      next_freq_a = frequency_word_a;
      next_freq_b = frequency_word_b;
      next_off_a = phase_offset_a;
      next_off_b = phase_offset_b;
      if (next_pready) begin
         next_pslverr = !addr_hit(paddr);
         unique case (paddr)
            `NPS_OFS_CTRL: next_prdata = {16'h0000, ctrl_word};
            `NPS_OFS_FREQ_A: next_prdata = 32'(frequency_word_a);
            `NPS_OFS_FREQ_B: next_prdata = 32'(frequency_word_b);
            `NPS_OFS_PHASE_A: next_prdata = 32'(phase_offset_a);
            `NPS_OFS_PHASE_B: next_prdata = 32'(phase_offset_b);
            `NPS_OFS_STATUS: next_prdata = 32'(acc);
            default: next_prdata = 32'h0000_0000;
         endcase
      end
      if (commit && pwrite) begin
         unique case (paddr)
            `NPS_OFS_CTRL: begin
               next_ctrl.freq_word_select = pwdata[`NPS_BIT_FREQ_SEL];
               next_ctrl.phase_offset_select = pwdata[`NPS_BIT_PSEL];
               next_ctrl.ramp_mode = pwdata[`NPS_BIT_MODE];
            end
            `NPS_OFS_FREQ_A: next_freq_a = pwdata[ACC_W-1:0];
            `NPS_OFS_FREQ_B: next_freq_b = pwdata[ACC_W-1:0];
            `NPS_OFS_PHASE_A: next_off_a = pwdata[PHASE_W-1:0];
            `NPS_OFS_PHASE_B: next_off_b = pwdata[PHASE_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `NPS_RST_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ctrl <= '0;
         frequency_word_a <= '0;
         frequency_word_b <= '0;
         phase_offset_a <= '0;
         phase_offset_b <= '0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         ctrl <= next_ctrl;
         frequency_word_a <= next_freq_a;
         frequency_word_b <= next_freq_b;
         phase_offset_a <= next_off_a;
         phase_offset_b <= next_off_b;
      end
   end

   // ***************************************************************
   // Falling-edge sampling of the select bits
   // ***************************************************************
   // Half a cycle of settling before the selects steer the datapath
   logic fword_sel_f;
   logic psel_f;

   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         fword_sel_f <= 1'b0;
         psel_f <= 1'b0;
      end else begin
         fword_sel_f <= ctrl.freq_word_select;
         psel_f <= ctrl.phase_offset_select;
      end
   end

   // ***************************************************************
   // NCO pipeline
   // ***************************************************************
   logic advance;
   logic [ACC_W-1:0] inc;
   logic [PHASE_W-1:0] off1;
   logic [PHASE_W-1:0] off2;
   logic [PHASE_W-1:0] phase12;
   logic [DAC_W-1:0] amp;
   logic [DAC_W-1:0] dly1;
   logic [DAC_W-1:0] dly2;
   logic [ACC_W-1:0] next_inc;
   logic [ACC_W-1:0] next_acc;
   logic [PHASE_W-1:0] next_off1;
   logic [PHASE_W-1:0] next_off2;
   logic [PHASE_W-1:0] next_phase12;
   logic [DAC_W-1:0] next_amp;
   logic [DAC_W-1:0] next_dly1;
   logic [DAC_W-1:0] next_dly2;

   // Whole pipeline freezes while the output buffer is full, so no
   // sample is dropped; the phase simply waits with it
   always_comb begin
      next_inc = inc;
      next_acc = acc;
      next_off1 = off1;
      next_off2 = off2;
      next_phase12 = phase12;
      next_amp = amp;
      next_dly1 = dly1;
      next_dly2 = dly2;
      if (advance) begin
         next_inc = fword_sel_f ? frequency_word_b : frequency_word_a;
         next_off1 = psel_f ? phase_offset_b : phase_offset_a;
         next_off2 = off1;
         // Natural wrap; the select never touches this register
         next_acc = acc + inc;
         // Offset counts align with the top bits; low bits dropped
         next_phase12 = acc[ACC_W-1 -: PHASE_W] + off2;
         next_amp = ctrl.ramp_mode ? phase12[PHASE_W-1 -: DAC_W]
                                   : sine_rom[phase12];
         // Two delay stages give the documented load-to-output latency
         next_dly1 = amp;
         next_dly2 = dly1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inc <= '0;
         acc <= '0;
         off1 <= '0;
         off2 <= '0;
         phase12 <= '0;
         amp <= '0;
         dly1 <= '0;
         dly2 <= '0;
      end else begin
         inc <= next_inc;
         acc <= next_acc;
         off1 <= next_off1;
         off2 <= next_off2;
         phase12 <= next_phase12;
         amp <= next_amp;
         dly1 <= next_dly1;
         dly2 <= next_dly2;
      end
   end

   // ***************************************************************
   // Two-entry output buffer
   // ***************************************************************
   logic [DAC_W-1:0] slot1;
   logic [1:0] count;
   logic [DAC_W-1:0] next_dac_data;
   logic [DAC_W-1:0] next_slot1;
   logic [1:0] next_count;
   logic next_dac_valid;
   logic pop;

   // Source always offers a word; ready toward it is a free slot
   always_comb begin
      advance = count != 2'h2;
      pop = dac_valid && dac_ready;
      next_dac_data = dac_data;
      next_slot1 = slot1;
      next_count = count;
      unique case (count)
         2'h0: begin
            next_dac_data = dly2;
            next_count = 2'h1;
         end
         2'h1: begin
            if (pop) begin
               next_dac_data = dly2;
            end else begin
               next_slot1 = dly2;
               next_count = 2'h2;
            end
         end
         default: begin
            if (pop) begin
               next_dac_data = slot1;
               next_count = 2'h1;
            end
         end
      endcase
      next_dac_valid = next_count != 2'h0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_data <= '0;
         slot1 <= '0;
         count <= 2'h0;
         dac_valid <= 1'b0;
      end else begin
         dac_data <= next_dac_data;
         slot1 <= next_slot1;
         count <= next_count;
         dac_valid <= next_dac_valid;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_acc_step;
      advance |=> acc == ACC_W'($past(acc) + $past(inc));
   endproperty
   a_acc_step: assert property (p_acc_step)
      else $error("accumulator step wrong");

   property p_acc_hold;
      !advance |=> $stable(acc) && $stable(phase12);
   endproperty
   a_acc_hold: assert property (p_acc_hold)
      else $error("pipeline moved while stalled");

   property p_inc_sel;
      advance && !fword_sel_f |=> inc == $past(frequency_word_a);
   endproperty
   a_inc_sel: assert property (p_inc_sel)
      else $error("increment not from word a");

   property p_trunc;
      advance |=> phase12 ==
         PHASE_W'($past(acc[ACC_W-1 -: PHASE_W]) + $past(off2));
   endproperty
   a_trunc: assert property (p_trunc)
      else $error("phase truncation wrong");

   property p_off_path;
      advance ##1 advance |=> off2 == $past(off1) &&
         $past(off1) == ($past(psel_f, 2) ? $past(phase_offset_b, 2)
                                          : $past(phase_offset_a, 2));
   endproperty
   a_off_path: assert property (p_off_path)
      else $error("phase offset select wrong");

   property p_ramp;
      advance && ctrl.ramp_mode |=> amp == $past(phase12[PHASE_W-1 -: DAC_W]);
   endproperty
   a_ramp: assert property (p_ramp)
      else $error("ramp word wrong");

   property p_sine;
      advance && !ctrl.ramp_mode |=> amp == sine_rom[$past(phase12)];
   endproperty
   a_sine: assert property (p_sine)
      else $error("sine word wrong");

   property p_dac_hold;
      dac_valid && !dac_ready |=> dac_valid && $stable(dac_data);
   endproperty
   a_dac_hold: assert property (p_dac_hold)
      else $error("output word lost under stall");

   property p_apb_wr;
      psel && penable && pready && pwrite && paddr == `NPS_OFS_FREQ_B
         |=> frequency_word_b == $past(pwdata[ACC_W-1:0]);
   endproperty
   a_apb_wr: assert property (p_apb_wr)
      else $error("frequency word b write lost");

endmodule : nps_nco_datapath
`default_nettype wire

// ==== testbench/nps_dac_model.sv ====
// Behavioural converter input that takes one word per handshake.
// Assumes dac_data and dac_valid come from logic clocked by pclk.
`timescale 1ns/1ps
`default_nettype none

module nps_dac_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [9:0] dac_data,
   input wire logic dac_valid,
   input wire logic stall,
   output logic dac_ready,
   output logic [9:0] word,
   output logic took
);
   // Ready follows the stall request, so the bench can play a slow part
   assign dac_ready = ~stall;

   // Capture one sample per handshake edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word <= 10'h000;
         took <= 1'b0;
      end else begin
         took <= dac_valid & dac_ready;
         if (dac_valid && dac_ready) begin
            word <= dac_data;
         end
      end
   end
endmodule : nps_dac_model
`default_nettype wire

// ==== testbench/nps_nco_datapath_tb_top.sv ====
// Self-checking bench for the phase-to-sine datapath over APB.
// Assumes registered APB answers and a two-word output buffer.
`timescale 1ns/1ps
`default_nettype none
`include "nps_params.svh"

module nps_nco_datapath_tb_top;
   logic pclk, presetn, psel, penable, pwrite, stall, pready, pslverr, er;
   logic dac_ready, dac_valid, took;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] dac_data, word, hold;
   logic [11:0] s_top, ph;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int land, n, lat;
   logic [7:0] r_adr [4] = '{`NPS_OFS_FREQ_A, `NPS_OFS_FREQ_B,
      `NPS_OFS_PHASE_A, `NPS_OFS_PHASE_B};
   logic [31:0] r_exp [4] = '{32'h0FFF_FFFF, 32'h0FFF_FFFF,
      32'h0000_0FFF, 32'h0000_0FFF};
   logic [11:0] s_ph [3] = '{12'h000, 12'h400, 12'hC00};
   logic [9:0] s_amp [3] = '{10'h200, 10'h3FF, 10'h001};

   nps_nco_datapath #(.ACC_W(28), .PHASE_W(12), .DAC_W(10)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dac_ready(dac_ready),
      .dac_data(dac_data), .dac_valid(dac_valid));

   nps_dac_model u_dac (.pclk(pclk), .presetn(presetn),
      .dac_data(dac_data), .dac_valid(dac_valid), .stall(stall),
      .dac_ready(dac_ready), .word(word), .took(took));

   // ***************************************************************
   // Clock, edge counter and watchdog
   // ***************************************************************
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk) cyc <= cyc + 1;

   // Whole run is several hundred cycles; this is far beyond it
   initial begin
      #400000;
      err_total++;
      close_out();
   end

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string msg);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
            seen, exp);
      end
   endtask : check

   // One APB transfer; entered right after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      if (k >= 40) err_total++;
      rd = prdata;
      er = pslverr;
      land = cyc;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Compare the step between successive taken ramp words
   task automatic steps(input logic [9:0] d, input logic slow);
      logic [9:0] prev, diff;
      int k, t;
      k = 0;
      t = 0;
      while (k < 24 && t < 400) begin
         @(posedge pclk);
         t++;
         stall <= slow && (t % 4 != 0);
         if (took === 1'b1) begin
            diff = word - prev;
            if (k > 0) check({22'h0, diff}, {22'h0, d}, "ramp step");
            prev = word;
            k++;
         end
      end
      @(posedge pclk);
      stall <= 1'b0;
      if (k < 24) err_total++;
   endtask : steps

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      stall = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `NPS_OFS_STATUS, 32'h0);
      check(rd, 32'h0, "accumulator after reset");
      apb(1'b0, `NPS_OFS_CTRL, 32'h0);
      check(rd, 32'h0, "control after reset");
      // Zero phase through the table sits at mid-scale
      check({22'h0, dac_data}, 32'h200, "zero phase word");
      // Only the three control bits and the word widths are kept
      apb(1'b1, `NPS_OFS_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, `NPS_OFS_CTRL, 32'h0);
      check(rd, 32'h0000_0C02, "control bits");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, r_adr[i], 32'hFFFF_FFFF);
         apb(1'b0, r_adr[i], 32'h0);
         check(rd, r_exp[i], "word width");
      end
      // Unmapped address is refused; status ignores writes quietly
      apb(1'b1, 8'h18, 32'h1234_5678);
      check({31'h0, er}, 32'h1, "unmapped write error");
      apb(1'b0, 8'h18, 32'h0);
      check({31'h0, er}, 32'h1, "unmapped read error");
      check(rd, 32'h0, "unmapped read data");
      apb(1'b1, `NPS_OFS_STATUS, 32'h1234_5678);
      check({31'h0, er}, 32'h0, "status write");
      // Ramp mode: one top-10 count per sample, then a wrapping step
      apb(1'b1, `NPS_OFS_PHASE_A, 32'h0);
      apb(1'b1, `NPS_OFS_FREQ_A, 32'h0004_0000);
      apb(1'b1, `NPS_OFS_FREQ_B, 32'h0FFC_0000);
      apb(1'b1, `NPS_OFS_CTRL, 32'h0000_0002);
      repeat (16) @(posedge pclk);
      steps(10'h001, 1'b0);
      steps(10'h001, 1'b1);
      // A stalled receiver sees the head word held
      @(posedge pclk);
      stall <= 1'b1;
      repeat (3) @(posedge pclk);
      hold = dac_data;
      repeat (5) begin
         @(posedge pclk);
         check({22'h0, dac_data}, {22'h0, hold}, "stalled word");
         check({31'h0, dac_valid}, 32'h1, "valid under stall");
      end
      stall <= 1'b0;
      steps(10'h001, 1'b0);
      apb(1'b1, `NPS_OFS_CTRL, 32'h0000_0802);
      repeat (16) @(posedge pclk);
      steps(10'h3FF, 1'b1);
      // Frozen phase, then an offset and its latency
      apb(1'b1, `NPS_OFS_CTRL, 32'h0000_0002);
      apb(1'b1, `NPS_OFS_FREQ_A, 32'h0);
      repeat (16) @(posedge pclk);
      apb(1'b0, `NPS_OFS_STATUS, 32'h0);
      s_top = rd[27:16];
      apb(1'b1, `NPS_OFS_PHASE_A, 32'h0000_0100);
      ph = s_top + 12'h100;
      n = 0;
      while (dac_data !== ph[11:2] && n < 40) begin
         @(posedge pclk);
         n++;
      end
      lat = cyc - land - 1;
      check({31'h0, lat == 7 || lat == 8}, 32'h1, "latency");
      check({22'h0, dac_data}, {22'h0, ph[11:2]}, "offset a");
      apb(1'b1, `NPS_OFS_PHASE_B, 32'h0000_0800);
      apb(1'b1, `NPS_OFS_CTRL, 32'h0000_0402);
      repeat (16) @(posedge pclk);
      ph = s_top + 12'h800;
      check({22'h0, dac_data}, {22'h0, ph[11:2]}, "offset b");
      // Sine table at three known phases
      apb(1'b1, `NPS_OFS_CTRL, 32'h0);
      for (int i = 0; i < 3; i++) begin
         ph = s_ph[i] - s_top;
         apb(1'b1, `NPS_OFS_PHASE_A, {20'h0, ph});
         repeat (16) @(posedge pclk);
         check({22'h0, dac_data}, {22'h0, s_amp[i]}, "sine");
      end
      close_out();
   end
endmodule : nps_nco_datapath_tb_top
`default_nettype wire
